/* File: include/rsc_pkg.sv */
/*
 Package of the reset source control block: register map, field
 positions, reset values, cause encoding, state type and timing counts.
 Assumes the block runs on hclk at 20 MHz and is reached over AHB-Lite.
*/
`default_nettype none
package rsc_pkg;
   // Clock
   localparam int CLK_PERIOD_NS = 50;

   // Register indices; byte address is four times the index
   localparam logic [29:0] IDX_RESET_SOURCE = 30'h0000_00ef;
   localparam logic [29:0] IDX_SUPPLY_MONITOR = 30'h0000_00ff;
   localparam logic [29:0] IDX_ENABLE_VIEW = 30'h0000_00f0;

   // Field positions, shared by cause vector and flags; BIT_MON_EN and BIT_MON_STAT are supply monitor bits
   localparam int BIT_USB = 7;
   localparam int BIT_FLASH = 6;
   localparam int BIT_CMP = 5;
   localparam int BIT_SW = 4;
   localparam int BIT_WDT = 3;
   localparam int BIT_MCD = 2;
   localparam int BIT_POR = 1;
   localparam int BIT_PIN = 0;
   localparam int BIT_MON_EN = 7;
   localparam int BIT_MON_STAT = 6;

   // Values left after power-on
   localparam logic [7:0] FLAGS_POR = 8'h02;
   localparam logic MON_EN_POR = 1'b1;

   // Restart address
   localparam logic [15:0] RESET_VECTOR = 16'h0000;

   // Timing figures in ns and derived cycle counts
   localparam int MCD_MIN_NS = 100000;
   localparam int MCD_TYP_NS = 220000;
   localparam int MCD_MAX_NS = 500000;
   localparam int MCD_CYCLES = MCD_TYP_NS / CLK_PERIOD_NS;
   localparam int MON_TURN_ON_NS = 100000;
   localparam int MON_CYCLES =
      (MON_TURN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RELEASE_NS = 5000;
   localparam int RELEASE_CYCLES =
      (RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMER_W = 16;
   localparam int REL_W = 8;

   // Synchroniser lanes of pin-level inputs
   localparam int SY_PIN = 0;
   localparam int SY_VBUS = 1;
   localparam int SY_CMP = 2;
   localparam int SY_VDD = 3;
   localparam int SY_SCLK = 4;
   localparam int SY_N = 5;
   localparam logic [SY_N-1:0] SYNC_RESET = 5'h01;

   typedef enum logic [1:0] {st_run, st_hold, st_release} rsc_state_e;

   typedef struct packed {
      rsc_state_e st;
      logic [SY_N-1:0] sync1;
      logic [SY_N-1:0] sync2;
      logic sclk_prev;
      logic usb_en;
      logic comp_en;
      logic mcd_en;
      logic vdd_sel;
      logic mon_en;
      logic sw_req;
      logic [7:0] flags;
      logic [REL_W-1:0] rel_cnt;
      logic wr_pend;
      logic [29:0] wr_idx;
      logic [31:0] rdata;
   } rsc_regs_s;
endpackage : rsc_pkg
`default_nettype wire

/* File: hdl/rsc_timer.sv */
/*
 Timeout counter: counts hclk cycles since clear was last high and
 raises expired once the count reaches COUNT, holding it until cleared.
 Assumes clear comes from logic on hclk.
*/
`timescale 1ns/1ns
`default_nettype none
module rsc_timer
   import rsc_pkg::*;
#(
   parameter int W = TIMER_W,
   parameter int COUNT = MON_CYCLES
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clear,
   output logic expired
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic done;
   } rsc_timer_s;

   localparam logic [W-1:0] LAST = W'(COUNT - 1);

   rsc_timer_s q;
   rsc_timer_s next_q;

   always_comb
   begin
      next_q = q;
      if (clear)
      begin
         next_q.cnt = '0;
         next_q.done = 1'b0;
      end
      else if (!q.done)
      begin
         if (q.cnt == LAST)
            next_q.done = 1'b1;
         else
            next_q.cnt = q.cnt + W'(1);
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         q <= '0;
      else
         q <= next_q;
   end

   assign expired = q.done;
endmodule : rsc_timer
`default_nettype wire

/* File: hdl/rsc_reset_source_control.sv */
/*
 Reset source control: collects reset causes into one system reset,
 records the cause flags, and holds the reset source register as an
 AHB-Lite slave with zero wait states.
 Assumes hresetn is the power-on reset of an always-on domain, and that
 watchdog, flash error and USB bus-reset inputs are hclk pulses/levels.
// Operation
// - Bit 7 write enables or disables USB as a reset source.
// - Enabled USB source resets on bus reset if USB function enabled.
// - Enabled USB source resets when bus-power level matches polarity.
// - USB reset sets USB flag and leaves the reset pin undriven.
// - Flash error flag reads 1 only after a flash access error reset.
// - Bit 5 enables active-low comparator reset; reads comparator cause.
// - Writing 1 to bit 4 forces reset; reads software cause.
// - Watchdog flag reads 1 exactly after a watchdog timeout reset.
// - Bit 2 enables clock-loss detector; reads detector cause.
// - Clock-loss timeout lies between 100 and 500 us, typically 220.
// - Power-on sets bit 1; writing bit 1 selects supply monitor source.
// - Other flags are meaningless while the power-on flag is set.
// - Pin reset flag reads 1 exactly after an external pin reset.
// - Read-modify-write sees stored enables, not cause flags.
// - At least 5 us pass between reset release and code execution.
// - Only power-on enables the supply monitor; other resets keep it.
// - Every reset restarts execution at address 0x0000.
*/
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module rsc_reset_source_control
   import rsc_pkg::*;
#(
   parameter int MCD_COUNT = MCD_CYCLES
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic rst_pin_n_in,
   output logic rst_pin_out,
   output logic rst_pin_oe,
   input wire logic vbus_in,
   input wire logic bus_power_polarity_select,
   input wire logic usb_bus_reset,
   input wire logic usb_function_enabled,
   input wire logic comparator_in,
   input wire logic comparator_enabled,
   input wire logic vdd_above_in,
   input wire logic sys_clk_in,
   input wire logic watchdog_timeout,
   input wire logic flash_error,
   output logic supply_monitor_enable,
   output logic system_reset_n,
   output logic [15:0] restart_address
);
   rsc_regs_s q;
   rsc_regs_s next_q;
   logic [7:0] cause;
   logic [7:0] enables;
   logic sclk_edge;
   logic mcd_clear;
   logic mcd_expired;
   logic mon_clear;
   logic mon_stable;
   logic pin_masked;
   logic take;
   logic [29:0] a_idx;

   // Clock-loss one-shot restarted by every sampled rising edge of the system clock
   assign sclk_edge = q.sync2[SY_SCLK] & ~q.sclk_prev;
   assign mcd_clear = ~q.mcd_en | sclk_edge;

   rsc_timer #(
      .W(TIMER_W),
      .COUNT(MCD_COUNT)
   ) u_mcd (
      .hclk(hclk),
      .hresetn(hresetn),
      .clear(mcd_clear),
      .expired(mcd_expired)
   );

   // Monitor counts as stable only after its turn-on time
   assign mon_clear = ~q.mon_en;

   rsc_timer #(
      .W(TIMER_W),
      .COUNT(MON_CYCLES)
   ) u_mon (
      .hclk(hclk),
      .hresetn(hresetn),
      .clear(mon_clear),
      .expired(mon_stable)
   );

   // Pin is ignored while this block drives it and through its release
   assign pin_masked = q.flags[BIT_POR] && (q.st != st_run);

   always_comb
   begin
      cause = '0;
      cause[BIT_USB] = q.usb_en &
         ((usb_bus_reset & usb_function_enabled) |
          (q.sync2[SY_VBUS] == bus_power_polarity_select));
      cause[BIT_FLASH] = flash_error;
      cause[BIT_CMP] = q.comp_en & comparator_enabled &
         ~q.sync2[SY_CMP];
      cause[BIT_SW] = q.sw_req;
      cause[BIT_WDT] = watchdog_timeout;
      cause[BIT_MCD] = q.mcd_en & mcd_expired;
      // Selecting an unready monitor resets, as the hardware would
      cause[BIT_POR] = q.vdd_sel &
         (~q.mon_en | ~mon_stable | ~q.sync2[SY_VDD]);
      cause[BIT_PIN] = ~q.sync2[SY_PIN] & ~pin_masked;
   end

   assign enables = {q.usb_en, 1'b0, q.comp_en, 1'b0, 1'b0, q.mcd_en,
                     q.vdd_sel, 1'b0};

   assign take = hsel & htrans[1] & hready;
   assign a_idx = haddr[31:2];

   always_comb
   begin
      next_q = q;
      next_q.sync1 = {sys_clk_in, vdd_above_in, comparator_in, vbus_in,
                      rst_pin_n_in};
      next_q.sync2 = q.sync1;
      next_q.sclk_prev = q.sync2[SY_SCLK];

      // Data phase of a write taken in the previous cycle
      if (q.wr_pend)
      begin
         if (q.wr_idx == IDX_RESET_SOURCE || q.wr_idx == IDX_ENABLE_VIEW)
         begin
            next_q.usb_en = hwdata[BIT_USB];
            next_q.comp_en = hwdata[BIT_CMP];
            next_q.mcd_en = hwdata[BIT_MCD];
            next_q.vdd_sel = hwdata[BIT_POR];
            if (hwdata[BIT_SW])
               next_q.sw_req = 1'b1;
         end
         else if (q.wr_idx == IDX_SUPPLY_MONITOR)
            next_q.mon_en = hwdata[BIT_MON_EN];
      end

      // Address phase: latch write target, prepare read data
      next_q.wr_pend = take & hwrite;
      next_q.wr_idx = a_idx;
      if (take && !hwrite)
      begin
         if (a_idx == IDX_RESET_SOURCE)
            next_q.rdata = {24'h000000, q.flags};
         else if (a_idx == IDX_ENABLE_VIEW)
            next_q.rdata = {24'h000000, enables};
         else if (a_idx == IDX_SUPPLY_MONITOR)
            next_q.rdata = {24'h000000, q.mon_en, q.sync2[SY_VDD],
                            6'h00};
         else
            next_q.rdata = 32'h0000_0000;
      end

      unique case (q.st)
         st_run:
         begin
            if (|cause)
            begin
               next_q.st = st_hold;
               next_q.flags = cause;
               // USB and comparator sources need re-arming; monitor enable
               // is kept so a brown-out stays covered
               next_q.usb_en = 1'b0;
               next_q.comp_en = 1'b0;
               next_q.sw_req = 1'b0;
            end
         end
         st_hold:
         begin
            next_q.flags = q.flags | cause;
            if (cause[BIT_POR])
               next_q.flags = FLAGS_POR;
            if (cause == 8'h00)
            begin
               next_q.st = st_release;
               next_q.rel_cnt = '0;
            end
         end
         st_release:
         begin
            if (|cause)
            begin
               next_q.st = st_hold;
               next_q.flags = q.flags | cause;
            end
            else if (q.rel_cnt == REL_W'(RELEASE_CYCLES - 1))
               next_q.st = st_run;
            else
               next_q.rel_cnt = q.rel_cnt + REL_W'(1);
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         q <= '0;
         q.st <= st_hold;
         q.sync1 <= SYNC_RESET;
         q.sync2 <= SYNC_RESET;
         q.flags <= FLAGS_POR;
         q.mon_en <= MON_EN_POR;
      end
      else
         q <= next_q;
   end

   // Only power-on or brown-out drives the pin low
   assign rst_pin_out = 1'b0;
   assign rst_pin_oe = (q.st == st_hold) && q.flags[BIT_POR];

   assign system_reset_n = (q.st == st_run);
   assign restart_address = RESET_VECTOR;
   assign supply_monitor_enable = q.mon_en;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = q.rdata;

   logic unused_ok;
   assign unused_ok = ^{hsize, MCD_MIN_NS[0], MCD_MAX_NS[0]};
endmodule : rsc_reset_source_control
`default_nettype wire

/* File: verification/rsc_asserts.sv */
/*
 Checker of the reset source control block, bound to its top module.
 Assumes hclk is the only clock and hresetn the power-on reset.
*/
`timescale 1ns/1ns
`default_nettype none
module rsc_asserts
   import rsc_pkg::*;
#(
   parameter int MCD_COUNT = MCD_CYCLES
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic rst_pin_out,
   input wire logic rst_pin_oe,
   input wire logic watchdog_timeout,
   input wire logic flash_error,
   input wire logic system_reset_n,
   input wire logic [15:0] restart_address
);
   logic wr_q;
   logic [7:0] low_cnt;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Data phase of a write to the reset source register
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         wr_q <= 1'b0;
      else
         wr_q <= hsel && htrans[1] && hready && hwrite &&
            haddr == {IDX_RESET_SOURCE, 2'b00};

   // Saturates so a long power-on hold cannot wrap
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         low_cnt <= 8'h00;
      else if (system_reset_n)
         low_cnt <= 8'h00;
      else if (low_cnt != 8'hff)
         low_cnt <= low_cnt + 8'h01;

   a_vector_zero: assert property (restart_address == 16'h0000)
      else $error("restart address not zero");
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus slave not ready or not okay");
   a_upper_zero: assert property (hrdata[31:8] == 24'h000000)
      else $error("upper read data bits not zero");
   a_wdt_reset: assert property (watchdog_timeout && system_reset_n
      |=> !system_reset_n) else $error("watchdog gave no reset");
   a_flash_reset: assert property (flash_error && system_reset_n
      |=> !system_reset_n) else $error("flash error gave no reset");
   a_sw_force: assert property (wr_q && hwdata[BIT_SW]
      && system_reset_n |-> ##[1:3] !system_reset_n)
      else $error("software reset missing");
   a_release_gap: assert property ($rose(system_reset_n)
      |-> low_cnt >= RELEASE_CYCLES) else $error("reset released too soon");
   a_reset_min: assert property ($fell(system_reset_n)
      |-> !system_reset_n [*8]) else $error("reset pulse too short");
   a_pin_quiet: assert property (rst_pin_oe
      |-> !rst_pin_out && !system_reset_n) else $error("pin driven in run");
endmodule : rsc_asserts

bind rsc_reset_source_control rsc_asserts #(
   .MCD_COUNT(MCD_COUNT)
) u_rsc_asserts (
   .hclk(hclk),
   .hresetn(hresetn),
   .hsel(hsel),
   .haddr(haddr),
   .htrans(htrans),
   .hwrite(hwrite),
   .hwdata(hwdata),
   .hready(hready),
   .hreadyout(hreadyout),
   .hresp(hresp),
   .hrdata(hrdata),
   .rst_pin_out(rst_pin_out),
   .rst_pin_oe(rst_pin_oe),
   .watchdog_timeout(watchdog_timeout),
   .flash_error(flash_error),
   .system_reset_n(system_reset_n),
   .restart_address(restart_address)
);
`default_nettype wire

/* File: verification/tb_top.sv */
/*
 Testbench of the reset source control block: AHB-Lite tasks and at least
 one scenario per reset cause. Assumes zero-wait-state slave behaviour.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import rsc_pkg::*;
;
   localparam int MCD_N = 20;
   localparam logic [31:0] A_RS = {IDX_RESET_SOURCE, 2'b00};
   localparam logic [31:0] A_EN = {IDX_ENABLE_VIEW, 2'b00};
   localparam logic [31:0] A_MON = {IDX_SUPPLY_MONITOR, 2'b00};
   logic hclk = 1'b0;
   logic hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rv;
   logic [1:0] htrans, sdiv = 2'b00;
   logic [2:0] hsize;
   logic rst_pin_n_in, rst_pin_out, rst_pin_oe, vbus_in, usb_bus_reset;
   logic bus_power_polarity_select, usb_function_enabled, comparator_in;
   logic comparator_enabled, vdd_above_in, sys_clk_in = 1'b0, sclk_run;
   logic watchdog_timeout, flash_error, supply_monitor_enable;
   logic system_reset_n;
   logic [15:0] restart_address;
   int fails = 0, cmp_count = 0, n;
   logic [31:0] exp_k [3] = '{32'h08, 32'h40, 32'h01};

   assign hready = hreadyout;
   always #25 hclk = ~hclk;
   // Monitored clock at hclk/8, stoppable for the clock-loss case
   always @(posedge hclk)
      if (sclk_run)
      begin
         sdiv <= sdiv + 2'b01;
         if (sdiv == 2'b11)
            sys_clk_in <= ~sys_clk_in;
      end

   rsc_reset_source_control #(
      .MCD_COUNT(MCD_N)
   ) u_rsc_reset_source_control (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .rst_pin_n_in(rst_pin_n_in),
      .rst_pin_out(rst_pin_out),
      .rst_pin_oe(rst_pin_oe),
      .vbus_in(vbus_in),
      .bus_power_polarity_select(bus_power_polarity_select),
      .usb_bus_reset(usb_bus_reset),
      .usb_function_enabled(usb_function_enabled),
      .comparator_in(comparator_in),
      .comparator_enabled(comparator_enabled),
      .vdd_above_in(vdd_above_in),
      .sys_clk_in(sys_clk_in),
      .watchdog_timeout(watchdog_timeout),
      .flash_error(flash_error),
      .supply_monitor_enable(supply_monitor_enable),
      .system_reset_n(system_reset_n),
      .restart_address(restart_address)
   );

   task check(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e)
      begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : check

   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] r);
      @(posedge hclk);
      {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, a, w};
      do @(posedge hclk); while (hready !== 1'b1);
      {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask : xfer

   task wait_rst(input logic v);
      for (int i = 0; i < 3000 && system_reset_n !== v; i++)
         @(posedge hclk);
   endtask : wait_rst

   task cause(input logic [31:0] f);
      wait_rst(1'b0);
      wait_rst(1'b1);
      xfer(1'b0, A_RS, 32'h0, rv);
      check(rv, f);
   endtask : cause

   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      #(50 * 20000);
      fails++;
      tally_and_finish;
   end

   initial
   begin
      {hresetn, hsel, haddr, htrans, hwrite, hwdata, hsize} = '0;
      {rst_pin_n_in, vbus_in, bus_power_polarity_select} = 3'b101;
      {usb_bus_reset, usb_function_enabled, comparator_in} = 3'b001;
      {comparator_enabled, vdd_above_in, sclk_run} = 3'b011;
      {watchdog_timeout, flash_error} = 2'b00;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      hsize <= 3'b010;
      cause(32'h02);
      check(restart_address, 32'h0);
      check(supply_monitor_enable, 32'h1);
      xfer(1'b0, A_MON, 32'h0, rv);
      check(rv, 32'hc0);
      // Monitor off across a software reset, then back on
      xfer(1'b1, A_MON, 32'h0, rv);
      xfer(1'b1, A_RS, 32'h10, rv);
      cause(32'h10);
      check(supply_monitor_enable, 32'h0);
      xfer(1'b0, A_MON, 32'h0, rv);
      check(rv, 32'h40);
      xfer(1'b1, A_MON, 32'h80, rv);
      for (int k = 0; k < 3; k++)
      begin
         @(posedge hclk);
         {watchdog_timeout, flash_error} <= {k == 0, k == 1};
         rst_pin_n_in <= (k != 2);
         repeat (k == 2 ? 6 : 1) @(posedge hclk);
         {watchdog_timeout, flash_error, rst_pin_n_in} <= 3'b001;
         cause(exp_k[k]);
      end
      @(posedge hclk);
      usb_bus_reset <= 1'b1;
      repeat (6) @(posedge hclk);
      check(system_reset_n, 32'h1);
      xfer(1'b1, A_EN, 32'h80, rv);
      xfer(1'b0, A_EN, 32'h0, rv);
      check(rv, 32'h80);
      repeat (6) @(posedge hclk);
      check(system_reset_n, 32'h1);
      usb_function_enabled <= 1'b1;
      wait_rst(1'b0);
      check(rst_pin_oe, 32'h0);
      cause(32'h80);
      {usb_bus_reset, usb_function_enabled} <= 2'b00;
      xfer(1'b1, A_RS, 32'h80, rv);
      vbus_in <= 1'b1;
      cause(32'h80);
      vbus_in <= 1'b0;
      // Comparator request counts only once the comparator is on
      xfer(1'b1, A_RS, 32'h20, rv);
      comparator_in <= 1'b0;
      repeat (6) @(posedge hclk);
      check(system_reset_n, 32'h1);
      comparator_enabled <= 1'b1;
      cause(32'h20);
      {comparator_in, comparator_enabled} <= 2'b10;
      repeat (2100) @(posedge hclk);
      xfer(1'b1, A_RS, 32'h02, rv);
      repeat (6) @(posedge hclk);
      check(system_reset_n, 32'h1);
      vdd_above_in <= 1'b0;
      repeat (8) @(posedge hclk);
      vdd_above_in <= 1'b1;
      cause(32'h02);
      xfer(1'b1, A_RS, 32'h04, rv);
      sclk_run <= 1'b0;
      n = 0;
      while (system_reset_n === 1'b1 && n < 100)
      begin
         @(posedge hclk);
         n++;
      end
      sclk_run <= 1'b1;
      check(n >= MCD_N * MCD_MIN_NS / MCD_TYP_NS, 32'h1);
      check(n <= MCD_N * MCD_MAX_NS / MCD_TYP_NS, 32'h1);
      cause(32'h04);
      xfer(1'b1, A_RS, 32'h0, rv);
      tally_and_finish;
   end
endmodule : tb_top
`default_nettype wire
